// >>> logic/prl_limiter.sv
// Function
// - Bps codes 101-115: 64 Kbps start and step; 640 Kbps on gigabit.
// - Bps codes 1-100: code times 1 Mbps; times 10 Mbps on gigabit.
// - Pps fine codes: 64 then 128 steps; 640 then 1280 on gigabit.
// - Pps coarse codes: code times 1.92 Kpps; 19.2 Kpps on gigabit.
// - Code 0 is full line rate; 10 Mbps ports treat 11-100 as unlimited.
// - Egress pps limits are also capped by a mapped bps bound.
// - On 10 Mbps ports a limit above 10 Mbps is unlimited.
// - Receive and transmit limiting run independently per port.
// - Ingress priorities are metered per mapped queue; each has its own rate only in four-queue mode.
// - Egress queues are metered per mapped queue; each has its own rate only in four-queue mode.
// - Bps frame length counts DA to FCS, optionally plus IFG or preamble.
// - Field [3:2] selects counted ingress frames: all, mcast, bcast, flood.
// - Over-limit ingress drops, or applies flow control when enabled.
// - Priority source from field [4:3]; 802.1p and DiffServ remapped to 0-3.
// - Queue-based limiting only when the global enable bit 3 is set.
// - Four-queue mode uses queues 0-3 codes; two-queue uses 0-1.
// - Egress leaky bucket per queue stretches the gap frame by frame.
// - When queue memory is exhausted, drop or flow control follows.
// - Top egress queue gets exact rate; lower queues by ratio 8:4:2:1.
module prl_limiter #(
  parameter int TICK_CYC = prl_pkg::REFILL_CYC
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic [7:0]        paddr_i,
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [31:0]       pwdata_i,
  output logic      [31:0]       prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  input  wire logic [1:0]        speed_i,
  input  wire logic              mem_full_i,
  input  wire prl_pkg::prl_rx_t  rx_i,
  output prl_pkg::prl_verd_t     verd_o,
  output logic                   rx_fc_o,
  input  wire prl_pkg::prl_tx_t  tx_i,
  output logic      [3:0]        eg_ok_o
);

  // ==========================================================
  // Helper functions
  // ==========================================================
  // Tokens are bits or milli-packets per refill period; 0 means unlimited.
  function automatic logic [23:0] rate_f(input logic [6:0] c, input logic [1:0] spd,
                                         input logic pps);
    logic [23:0] k;
    logic [23:0] r;
    k = {17'h0_0000, c};
    r = 24'h00_0000;
    if (c == 7'h00) begin
      if (pps) r = (spd == prl_pkg::SPD_1000) ? 24'(prl_pkg::PPS_LINE * 100) : prl_pkg::PPS_LINE;
      else if (spd == prl_pkg::SPD_1000) r = prl_pkg::KBPS_L1000;
      else r = (spd == prl_pkg::SPD_100) ? prl_pkg::KBPS_L100 : prl_pkg::KBPS_L10;
    end else if (c <= 7'h64) begin
      r = pps ? 24'(k * prl_pkg::PPS_COARSE) : 24'(k * prl_pkg::KBPS_COARSE);
    end else if (c <= 7'h73) begin
      if (!pps) r = 24'((k - 24'h00_0064) * prl_pkg::KBPS_FINE);
      else if (c == 7'h65) r = prl_pkg::PPS_FINE0;
      else r = 24'((k - 24'h00_0065) * prl_pkg::PPS_FSTEP);
    end
    if (spd == prl_pkg::SPD_1000 && c != 7'h00) r = 24'(r * prl_pkg::GIG_MUL);
    if (spd == prl_pkg::SPD_10 && c > 7'h0A && c <= 7'h64) r = 24'h00_0000;
    return r;
  endfunction

  function automatic logic [6:0] bound_f(input logic [6:0] c);
    logic [6:0] b;
    b = c;
    case (c)
      7'h01:   b = 7'h03;
      7'h02:   b = 7'h06;
      7'h65:   b = 7'h66;
      7'h66:   b = 7'h68;
      7'h67:   b = 7'h6C;
      7'h68:   b = 7'h70;
      default: begin
        if (c >= 7'h03 && c <= 7'h0A) b = 7'h0A;
        else if (c >= 7'h69 && c <= 7'h6B) b = 7'h01;
        else if (c >= 7'h6C && c <= 7'h70) b = 7'h02;
        else if (c >= 7'h71 && c <= 7'h73) b = 7'h03;
      end
    endcase
    return b;
  endfunction

  function automatic logic [23:0] minr_f(input logic [23:0] a, input logic [23:0] b);
    if (a == 24'h00_0000) return b;
    if (b == 24'h00_0000) return a;
    return (a < b) ? a : b;
  endfunction

  function automatic logic [1:0] qmap_f(input logic [1:0] p, input logic [1:0] split,
                                        input logic en);
    if (!en) return 2'h0;
    if (split == prl_pkg::SPLIT_4) return p;
    if (split == prl_pkg::SPLIT_2) return {1'b0, p[1]};
    return 2'h0;
  endfunction

  function automatic logic [31:0] cost_f(input logic [10:0] len, input logic [1:0] opt,
                                         input logic pps);
    logic [10:0] n;
    n = len;
    if (opt[0]) n = n + prl_pkg::IFG_BYTES;
    if (opt[1]) n = n + prl_pkg::PRE_BYTES;
    return pps ? prl_pkg::MPKT_COST : {18'h0_0000, n, 3'h0};
  endfunction

  // Credit may go negative so one large frame can pass a slow bucket.
  function automatic logic signed [31:0] bucket_f(input logic signed [31:0] c,
                                                  input logic [23:0] inc, input logic tick,
                                                  input logic dbt, input logic [31:0] cost);
    logic signed [31:0] n;
    n = c;
    if (inc == 24'h00_0000) return 32'sh0000_0000;
    if (tick) n = n + $signed({8'h00, inc});
    if (dbt) n = n - $signed(cost);
    if (n > $signed({8'h00, inc})) n = $signed({8'h00, inc});
    return n;
  endfunction

  // ==========================================================
  // Registers
  // ==========================================================
  logic [6:0]         rlctl_reg;
  logic [6:0]         pctl0_reg;
  logic               qen_reg;
  logic [6:0]         ing_code_reg [4];
  logic [6:0]         egr_code_reg [4];
  logic [15:0]        ratio_reg;
  logic [15:0]        pcp_reg;
  logic [31:0]        dscp_reg [4];
  logic [15:0]        drops_reg;
  logic signed [31:0] ic_reg [4];
  logic signed [31:0] ec_reg [4];
  logic signed [31:0] eb_reg [4];
  logic [31:0]        tick_cnt_reg;
  logic               tick_reg;
  logic [31:0]        rd_next;
  logic               err_next;
  logic [23:0]        iinc [4];
  logic [23:0]        ainc [4];
  logic [23:0]        binc [4];
  logic [3:0]         iok;
  logic [3:0]         eok;
  logic [1:0]         prio;
  logic [1:0]         rq;
  logic [1:0]         tq;
  logic [1:0]         top;
  logic               rx_sel;
  logic               rx_pass;
  logic [31:0]        rcost;
  logic [31:0]        tcost;

  wire logic wr_en = psel_i & penable_i & pready_o & pwrite_i;
  wire logic ipps  = rlctl_reg[prl_pkg::F_IPPS];
  wire logic epps  = rlctl_reg[prl_pkg::F_EPPS];
  wire logic [1:0] split = pctl0_reg[prl_pkg::F_SPLIT +: 2];

  // ==========================================================
  // APB slave
  // ==========================================================
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pready_o  <= 1'b0;
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= psel_i & ~penable_i;
      prdata_o  <= (psel_i & ~penable_i & ~pwrite_i & ~err_next) ? rd_next : 32'h0000_0000;
      pslverr_o <= psel_i & ~penable_i & err_next;
    end
  end

  always_comb begin
    rd_next  = 32'h0000_0000;
    err_next = 1'b0;
    case (paddr_i[7:4])
      prl_pkg::A_ING0[7:4]:  rd_next = {25'h0, ing_code_reg[paddr_i[3:2]]};
      prl_pkg::A_EGR0[7:4]:  rd_next = {25'h0, egr_code_reg[paddr_i[3:2]]};
      prl_pkg::A_DSCP0[7:4]: rd_next = dscp_reg[paddr_i[3:2]];
      default: begin
        case (paddr_i)
          prl_pkg::A_RLCTL: rd_next = {25'h0, rlctl_reg};
          prl_pkg::A_PCTL0: rd_next = {25'h0, pctl0_reg};
          prl_pkg::A_GCTL:  rd_next = {28'h0, qen_reg, 3'h0};
          prl_pkg::A_STAT:  rd_next = {23'h0, mem_full_i, eok, iok};
          prl_pkg::A_RATIO: rd_next = {16'h0, ratio_reg};
          prl_pkg::A_PCP:   rd_next = {16'h0, pcp_reg};
          prl_pkg::A_DROPS: rd_next = {16'h0, drops_reg};
          default:          err_next = 1'b1;
        endcase
      end
    endcase
    if (paddr_i[1:0] != 2'h0) err_next = 1'b1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rlctl_reg <= 7'h00;
      pctl0_reg <= 7'h00;
      qen_reg   <= 1'b0;
      ratio_reg <= prl_pkg::RST_RATIO;
      pcp_reg   <= prl_pkg::RST_PCP;
      for (int i = 0; i < 4; i++) begin
        ing_code_reg[i] <= prl_pkg::RST_CODE;
        egr_code_reg[i] <= prl_pkg::RST_CODE;
        dscp_reg[i]     <= 32'(prl_pkg::RST_DSCP1 * i);
      end
    end else if (wr_en && paddr_i[1:0] == 2'h0) begin
      case (paddr_i[7:4])
        prl_pkg::A_ING0[7:4]:  ing_code_reg[paddr_i[3:2]] <= pwdata_i[6:0];
        prl_pkg::A_EGR0[7:4]:  egr_code_reg[paddr_i[3:2]] <= pwdata_i[6:0];
        prl_pkg::A_DSCP0[7:4]: dscp_reg[paddr_i[3:2]] <= pwdata_i;
        default: begin
          case (paddr_i)
            prl_pkg::A_RLCTL: rlctl_reg <= pwdata_i[6:0];
            prl_pkg::A_PCTL0: pctl0_reg <= pwdata_i[6:0];
            prl_pkg::A_GCTL:  qen_reg   <= pwdata_i[prl_pkg::F_QEN];
            prl_pkg::A_RATIO: ratio_reg <= pwdata_i[15:0];
            prl_pkg::A_PCP:   pcp_reg   <= pwdata_i[15:0];
            default:          qen_reg   <= qen_reg;
          endcase
        end
      endcase
    end
  end

  // ==========================================================
  // Refill tick
  // ==========================================================
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_cnt_reg <= 32'h0000_0000;
      tick_reg     <= 1'b0;
    end else begin
      tick_reg     <= (tick_cnt_reg == 32'(TICK_CYC - 1));
      tick_cnt_reg <= (tick_cnt_reg == 32'(TICK_CYC - 1)) ? 32'h0000_0000 : tick_cnt_reg + 1;
    end
  end

  // ==========================================================
  // Rates
  // ==========================================================
  always_comb begin
    top = (split == prl_pkg::SPLIT_4) ? 2'h3 : {1'b0, split == prl_pkg::SPLIT_2};
    for (int i = 0; i < 4; i++) begin
      iinc[i] = rate_f(ing_code_reg[i], speed_i, ipps);
      ainc[i] = rate_f(egr_code_reg[i], speed_i, epps);
      binc[i] = epps ? rate_f(bound_f(egr_code_reg[i]), speed_i, 1'b0) : 24'h00_0000;
    end
    // Lower queues are held to a ratio of the top queue, whose weight is 8.
    for (int i = 0; i < 4; i++) begin
      if (qen_reg && split != prl_pkg::SPLIT_1 && 2'(i) < top && ainc[top] != 24'h00_0000)
        ainc[i] = minr_f(ainc[i], 24'(({4'h0, ainc[top]} * ratio_reg[4*i +: 4]) >> 3) |
                         24'h00_0001);
    end
    for (int i = 0; i < 4; i++) begin
      iok[i] = ~ic_reg[i][31];
      eok[i] = ~ec_reg[i][31] & ~eb_reg[i][31];
    end
  end

  // ==========================================================
  // Ingress metering
  // ==========================================================
  always_comb begin
    case (pctl0_reg[prl_pkg::F_PSRC +: 2])
      2'h1:    prio = pcp_reg[2*rx_i.pcp +: 2];
      2'h2:    prio = dscp_reg[rx_i.dscp[5:4]][2*rx_i.dscp[3:0] +: 2];
      default: prio = pctl0_reg[prl_pkg::F_DPRI +: 2];
    endcase
    rq = qmap_f(prio, split, qen_reg);
    case (rlctl_reg[prl_pkg::F_TYPE +: 2])
      2'h1:    rx_sel = rx_i.mcast;
      2'h2:    rx_sel = rx_i.bcast;
      2'h3:    rx_sel = rx_i.flood;
      default: rx_sel = 1'b1;
    endcase
    rx_pass = rlctl_reg[prl_pkg::F_IFC] | (~mem_full_i & (~rx_sel | iok[rq]));
    rcost   = cost_f(rx_i.len, rlctl_reg[prl_pkg::F_LEN +: 2], ipps);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 4; i++) ic_reg[i] <= 32'sh0000_0000;
    end else begin
      for (int i = 0; i < 4; i++)
        ic_reg[i] <= bucket_f(ic_reg[i], iinc[i], tick_reg,
                              rx_i.vld & rx_sel & rx_pass & (rq == 2'(i)), rcost);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      verd_o    <= '0;
      rx_fc_o   <= 1'b0;
      drops_reg <= 16'h0000;
    end else begin
      verd_o.vld <= rx_i.vld;
      verd_o.drop <= rx_i.vld & ~rx_pass;
      rx_fc_o    <= rlctl_reg[prl_pkg::F_IFC] & (mem_full_i | ~&iok);
      if (rx_i.vld && !rx_pass && drops_reg != 16'hFFFF) drops_reg <= drops_reg + 16'h0001;
    end
  end

  // ==========================================================
  // Egress shaping
  // ==========================================================
  assign tq    = qmap_f(tx_i.q, split, qen_reg);
  assign tcost = cost_f(tx_i.len, rlctl_reg[prl_pkg::F_LEN +: 2], 1'b0);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 4; i++) begin
        ec_reg[i] <= 32'sh0000_0000;
        eb_reg[i] <= 32'sh0000_0000;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        ec_reg[i] <= bucket_f(ec_reg[i], ainc[i], tick_reg, tx_i.vld & (tq == 2'(i)),
                              epps ? prl_pkg::MPKT_COST : tcost);
        eb_reg[i] <= bucket_f(eb_reg[i], binc[i], tick_reg, tx_i.vld & (tq == 2'(i)),
                              tcost);
      end
    end
  end

  // A queue waits after a frame until its credit recovers, stretching the gap.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      eg_ok_o <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++)
        eg_ok_o[i] <= eok[qmap_f(2'(i), split, qen_reg)];
    end
  end

endmodule

// >>> logic/prl_pkg.sv
package prl_pkg;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int CLK_MHZ    = 125;
  localparam int REFILL_US  = 1000;
  localparam int REFILL_CYC = REFILL_US * CLK_MHZ;

  // ==========================================================
  // Register offsets
  // ==========================================================
  localparam logic [7:0] A_RLCTL = 8'h00;
  localparam logic [7:0] A_PCTL0 = 8'h04;
  localparam logic [7:0] A_GCTL  = 8'h08;
  localparam logic [7:0] A_STAT  = 8'h0C;
  localparam logic [7:0] A_ING0  = 8'h10;
  localparam logic [7:0] A_EGR0  = 8'h20;
  localparam logic [7:0] A_RATIO = 8'h30;
  localparam logic [7:0] A_PCP   = 8'h34;
  localparam logic [7:0] A_DSCP0 = 8'h40;
  localparam logic [7:0] A_DROPS = 8'h50;

  // ==========================================================
  // Field positions and reset values
  // ==========================================================
  localparam int F_LEN   = 0;
  localparam int F_TYPE  = 2;
  localparam int F_IFC   = 4;
  localparam int F_IPPS  = 5;
  localparam int F_EPPS  = 6;
  localparam int F_DPRI  = 0;
  localparam int F_PSRC  = 3;
  localparam int F_SPLIT = 5;
  localparam int F_QEN   = 3;
  localparam logic [15:0] RST_RATIO = 16'h8421;
  localparam logic [15:0] RST_PCP   = 16'hFA50;
  localparam logic [31:0] RST_DSCP1 = 32'h5555_5555;
  localparam logic [6:0]  RST_CODE  = 7'h00;

  // ==========================================================
  // Speeds, modes and rate steps
  // ==========================================================
  localparam logic [1:0] SPD_10   = 2'h0;
  localparam logic [1:0] SPD_100  = 2'h1;
  localparam logic [1:0] SPD_1000 = 2'h2;
  localparam logic [1:0] SPLIT_1  = 2'h0;
  localparam logic [1:0] SPLIT_2  = 2'h1;
  localparam logic [1:0] SPLIT_4  = 2'h2;
  localparam logic [23:0] KBPS_FINE   = 24'h00_0040;
  localparam logic [23:0] KBPS_COARSE = 24'h00_03E8;
  localparam logic [23:0] PPS_FINE0   = 24'h00_0040;
  localparam logic [23:0] PPS_FSTEP   = 24'h00_0080;
  localparam logic [23:0] PPS_COARSE  = 24'h00_0780;
  localparam logic [23:0] PPS_LINE    = 24'h00_4B00;
  localparam logic [23:0] KBPS_L10    = 24'h00_2710;
  localparam logic [23:0] KBPS_L100   = 24'h01_86A0;
  localparam logic [23:0] KBPS_L1000  = 24'h0F_4240;
  localparam logic [23:0] GIG_MUL     = 24'h00_000A;
  localparam logic [31:0] MPKT_COST   = 32'h0000_03E8;
  localparam logic [10:0] IFG_BYTES   = 11'h00C;
  localparam logic [10:0] PRE_BYTES   = 11'h008;

  // ==========================================================
  // Carriers
  // ==========================================================
  typedef struct packed {
    logic        vld;
    logic [10:0] len;
    logic [2:0]  pcp;
    logic [5:0]  dscp;
    logic        mcast;
    logic        bcast;
    logic        flood;
  } prl_rx_t;

  typedef struct packed {
    logic        vld;
    logic [1:0]  q;
    logic [10:0] len;
  } prl_tx_t;

  typedef struct packed {
    logic vld;
    logic drop;
  } prl_verd_t;

endpackage

// >>> testbench/prl_limiter_checker.sv
module prl_limiter_checker (
  input wire logic               clk_i,
  input wire logic               rst_i,
  input wire logic [7:0]         paddr_i,
  input wire logic               psel_i,
  input wire logic               penable_i,
  input wire logic [31:0]        prdata_o,
  input wire logic               pready_o,
  input wire logic               pslverr_o,
  input wire logic               mem_full_i,
  input wire prl_pkg::prl_rx_t   rx_i,
  input wire prl_pkg::prl_verd_t verd_o,
  input wire logic               rx_fc_o,
  input wire logic [3:0]         eg_ok_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // ==========================================================
  // Bus sequences
  // ==========================================================
  sequence s_setup;
    psel_i && !penable_i;
  endsequence

  sequence s_bad_setup;
    s_setup ##0 (paddr_i[1:0] != 2'h0);
  endsequence

  // Outputs stay cleared while reset is held, whatever the default disable says.
  property p_rst_quiet;
    disable iff (1'b0)
    rst_i |=> !verd_o.vld && !pready_o && !rx_fc_o && (eg_ok_o == 4'h0);
  endproperty

  // ==========================================================
  // Assertions
  // ==========================================================
  a_ready_setup: assert property (s_setup |=> pready_o)
    else $error("pready missing after setup");
  a_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("pready held longer than one cycle");
  a_bad_addr: assert property (s_bad_setup |=> pslverr_o && (prdata_o == 32'h0000_0000))
    else $error("misaligned access not refused");
  a_rdata_quiet: assert property (!pready_o |-> (prdata_o == 32'h0000_0000) && !pslverr_o)
    else $error("read data outside access cycle");
  a_verd_timing: assert property (rx_i.vld |=> verd_o.vld)
    else $error("verdict not one cycle after frame");
  a_verd_only: assert property (!rx_i.vld |=> !verd_o.vld)
    else $error("verdict without frame");
  a_fc_no_drop: assert property (rx_fc_o && verd_o.vld |-> !verd_o.drop)
    else $error("drop while flow control active");
  a_full_drops: assert property (rx_i.vld && mem_full_i && $past(mem_full_i) && !rx_fc_o
    |=> verd_o.drop)
    else $error("frame kept while memory full");
  a_rst_quiet: assert property (p_rst_quiet)
    else $error("outputs active during reset");
  a_egok_release: assert property ($fell(rst_i) |=> eg_ok_o == 4'hF)
    else $error("egress not open after reset");
endmodule

bind prl_limiter prl_limiter_checker chk_u (
  .clk_i      (clk_i),
  .rst_i      (rst_i),
  .paddr_i    (paddr_i),
  .psel_i     (psel_i),
  .penable_i  (penable_i),
  .prdata_o   (prdata_o),
  .pready_o   (pready_o),
  .pslverr_o  (pslverr_o),
  .mem_full_i (mem_full_i),
  .rx_i       (rx_i),
  .verd_o     (verd_o),
  .rx_fc_o    (rx_fc_o),
  .eg_ok_o    (eg_ok_o)
);

// >>> testbench/prl_mac_model.sv
module prl_mac_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [3:0]  eg_ok_i,
  input  wire logic        go_i,
  input  wire logic [1:0]  q_i,
  input  wire logic [10:0] len_i,
  output prl_pkg::prl_tx_t tx_o
);
  logic armed_reg;

  // One frame per request, started only while its queue is open; idle length toggles.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      armed_reg <= 1'b0;
      tx_o      <= '0;
    end else begin
      tx_o.vld <= 1'b0;
      tx_o.len <= ~tx_o.len;
      if (go_i) begin
        armed_reg <= 1'b1;
      end else if (armed_reg && eg_ok_i[q_i]) begin
        armed_reg <= 1'b0;
        tx_o      <= '{vld: 1'b1, q: q_i, len: len_i};
      end
    end
  end
endmodule

// >>> testbench/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK = 100;
  logic               clk_i;
  logic               rst_i;
  logic [7:0]         paddr_i;
  logic               psel_i;
  logic               penable_i;
  logic               pwrite_i;
  logic [31:0]        pwdata_i;
  logic [31:0]        prdata_o;
  logic               pready_o;
  logic               pslverr_o;
  logic [1:0]         speed_i;
  logic               mem_full_i;
  prl_pkg::prl_rx_t   rx_i;
  prl_pkg::prl_verd_t verd_o;
  logic               rx_fc_o;
  prl_pkg::prl_tx_t   tx;
  logic [3:0]         eg_ok_o;
  logic               go;
  logic [31:0]        rd;
  logic               er;
  int                 n;
  int                 fail_count;
  int                 samples_checked;

  prl_limiter #(.TICK_CYC(TICK)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .paddr_i(paddr_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .speed_i(speed_i), .mem_full_i(mem_full_i),
    .rx_i(rx_i), .verd_o(verd_o), .rx_fc_o(rx_fc_o), .tx_i(tx), .eg_ok_o(eg_ok_o)
  );

  prl_mac_model mac_u (
    .clk_i(clk_i), .rst_i(rst_i), .eg_ok_i(eg_ok_o), .go_i(go), .q_i(2'h0),
    .len_i(11'h0FA), .tx_o(tx)
  );

  // ==========================================================
  // Tasks
  // ==========================================================
  task close_out;
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    psel_i   <= 1'b1;
    paddr_i  <= a;
    pwrite_i <= w;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (pready_o !== 1'b1 && k < 16);
    if (k >= 16) begin
      fail_count++;
      close_out();
    end else begin
      rd = prdata_o;
      er = pslverr_o;
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
    end
  endtask

  task rdc(input logic [7:0] a, input logic [31:0] exp, input logic eexp);
    apb(a, 1'b0, 32'h0000_0000);
    chk("prdata", rd, exp);
    chk("pslverr", {31'h0, er}, {31'h0, eexp});
  endtask

  task reset_dut;
    rst_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask

  task frame(input logic [10:0] l, input logic m, input logic dexp);
    @(posedge clk_i);
    rx_i <= '{vld: 1'b1, len: l, pcp: 3'h0, dscp: 6'h00, mcast: m, bcast: 1'b0, flood: 1'b0};
    @(posedge clk_i);
    rx_i.vld <= 1'b0;
    @(posedge clk_i);
    chk("verd_vld", {31'h0, verd_o.vld}, 32'h0000_0001);
    chk("verd_drop", {31'h0, verd_o.drop}, {31'h0, dexp});
  endtask

  // Two frames back to back, then a third after s refill periods.
  task probe(input logic [6:0] c, input logic [10:0] l, input int s,
             input logic [31:0] ctl, input logic e3);
    reset_dut();
    apb(prl_pkg::A_RLCTL, 1'b1, ctl);
    apb(prl_pkg::A_ING0, 1'b1, {25'h000_0000, c});
    frame(l, 1'b0, 1'b0);
    frame(l, 1'b0, 1'b1);
    repeat (s * TICK) @(posedge clk_i);
    frame(l, 1'b0, e3);
  endtask

  // ==========================================================
  // Stimulus
  // ==========================================================
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  initial begin
    repeat (100000) @(posedge clk_i);
    fail_count++;
    close_out();
  end

  initial begin
    rst_i = 1'b1;
    paddr_i = 8'h00;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    pwdata_i = 32'h0000_0000;
    speed_i = prl_pkg::SPD_100;
    mem_full_i = 1'b0;
    rx_i = '0;
    go = 1'b0;
    fail_count = 0;
    samples_checked = 0;
    reset_dut();
    rdc(prl_pkg::A_RATIO, 32'h0000_8421, 1'b0);
    rdc(prl_pkg::A_PCP, 32'h0000_FA50, 1'b0);
    rdc(prl_pkg::A_DSCP0 + 8'h04, 32'h5555_5555, 1'b0);
    rdc(prl_pkg::A_ING0, 32'h0000_0000, 1'b0);
    rdc(8'h03, 32'h0000_0000, 1'b1);
    rdc(8'hFC, 32'h0000_0000, 1'b1);
    apb(prl_pkg::A_ING0, 1'b1, 32'hFFFF_FFFF);
    rdc(prl_pkg::A_ING0, 32'h0000_007F, 1'b0);
    rdc(prl_pkg::A_ING0 + 8'h03, 32'h0000_0000, 1'b1);
    probe(7'h01, 11'h1F4, 1, 32'h0000_0000, 1'b1);
    probe(7'h65, 11'h040, 3, 32'h0000_0000, 1'b1);
    probe(7'h65, 11'h040, 8, 32'h0000_0000, 1'b0);
    probe(7'h65, 11'h040, 8, 32'h0000_0001, 1'b1);
    probe(7'h66, 11'h040, 3, 32'h0000_0020, 1'b1);
    speed_i <= prl_pkg::SPD_1000;
    probe(7'h65, 11'h040, 1, 32'h0000_0000, 1'b0);
    speed_i <= prl_pkg::SPD_100;
    reset_dut();
    apb(prl_pkg::A_GCTL, 1'b1, 32'h0000_0008);
    apb(prl_pkg::A_PCTL0, 1'b1, 32'h0000_0041);
    apb(prl_pkg::A_ING0, 1'b1, 32'h0000_0001);
    apb(prl_pkg::A_ING0 + 8'h04, 1'b1, 32'h0000_007F);
    frame(11'h1F4, 1'b0, 1'b0);
    frame(11'h1F4, 1'b0, 1'b0);
    reset_dut();
    apb(prl_pkg::A_ING0, 1'b1, 32'h0000_0001);
    apb(prl_pkg::A_RLCTL, 1'b1, 32'h0000_0004);
    frame(11'h1F4, 1'b0, 1'b0);
    frame(11'h1F4, 1'b0, 1'b0);
    frame(11'h1F4, 1'b1, 1'b0);
    frame(11'h1F4, 1'b1, 1'b1);
    apb(prl_pkg::A_RLCTL, 1'b1, 32'h0000_0014);
    frame(11'h1F4, 1'b1, 1'b0);
    chk("rx_fc", {31'h0, rx_fc_o}, 32'h0000_0001);
    apb(prl_pkg::A_RLCTL, 1'b1, 32'h0000_0000);
    apb(prl_pkg::A_ING0, 1'b1, 32'h0000_007F);
    mem_full_i <= 1'b1;
    frame(11'h040, 1'b0, 1'b1);
    mem_full_i <= 1'b0;
    frame(11'h040, 1'b0, 1'b0);
    reset_dut();
    speed_i <= prl_pkg::SPD_10;
    apb(prl_pkg::A_ING0, 1'b1, 32'h0000_0032);
    frame(11'h1F4, 1'b0, 1'b0);
    frame(11'h1F4, 1'b0, 1'b0);
    probe(7'h65, 11'h040, 3, 32'h0000_0000, 1'b1);
    speed_i <= prl_pkg::SPD_100;
    reset_dut();
    apb(prl_pkg::A_EGR0, 1'b1, 32'h0000_0001);
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    for (n = 0; n < 50 && tx.vld !== 1'b1; n++) @(posedge clk_i);
    chk("tx_sent", {31'h0, tx.vld}, 32'h0000_0001);
    repeat (2) @(posedge clk_i);
    // Without queue limiting every queue shares the port bucket, so all close.
    chk("eg_ok0", {28'h0, eg_ok_o}, 32'h0000_0000);
    frame(11'h1F4, 1'b0, 1'b0);
    for (n = 0; n < 5 * TICK && eg_ok_o[0] !== 1'b1; n++) @(posedge clk_i);
    chk("eg_ok0_back", {31'h0, eg_ok_o[0]}, 32'h0000_0001);
    chk("eg_gap", {31'h0, n > TICK}, 32'h0000_0001);
    close_out();
  end
endmodule
